// File: adc_ctl_params.svh
// constants for the converter mode and input control block
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH
`define CCTL_INDEX 4'h2
`define STATUS_ADDR 8'h00
`define MODE_ADDR 8'h04
`define CCTL_ADDR 8'h08
`define FILT_ADDR 8'h0C
`define SFACT_ADDR 8'h10
`define DECODE_ADDR 8'h14
`define CCTL_RST 8'h07
`define MODE_RST 8'h00
`define SF_RST 8'h45
`define SF_MAX 8'hFF
`define MODE_CHOP_BIT 4
`define MODE_CFG_BIT 5
`define ST_RDY_BIT 0
`define ST_BUSY_BIT 1
`define CCTL_BIP_BIT 3
`define RANGE_BASE_MV 10'h014
`define RANGE_TOP_CODE 3'h5
`define CAL_TIME_US 100
`define CLK_MHZ 20
`define CAL_CYCLES (`CAL_TIME_US * `CLK_MHZ)
`define NUM_PAIRS 5
`endif

// File: adc_ctl_pkg.sv
// types for the converter mode and input control block
package adc_ctl_pkg;
	typedef enum logic [2:0] {
		MD_PDOWN = 3'b000,
		MD_IDLE = 3'b001,
		MD_SINGLE = 3'b010,
		MD_CONT = 3'b011,
		MD_ZS_INT = 3'b100,
		MD_FS_INT = 3'b101,
		MD_ZS_SYS = 3'b110,
		MD_FS_SYS = 3'b111
	} conv_mode_t;
	typedef enum logic [1:0] {
		CAL_OFF = 2'b00,
		CAL_RUN = 2'b01,
		CAL_END = 2'b10
	} cal_state_t;
endpackage

// File: adc_mod_model.sv
// behavioural modulator model: finish pulses and calibration results
`timescale 1ns/1ps
`default_nettype none
module adc_mod_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bench control
	input wire logic fire,
	input wire logic [23:0] val,
	// towards the block
	output logic conv_done,
	output logic [23:0] cal_value
);
	// finish pulse one cycle after the bench asks for it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			conv_done <= 1'b0;
		end else begin
			conv_done <= fire;
		end
	end
	// result held steady so its sampling moment does not matter
	assign cal_value = val;
endmodule
`default_nettype wire

// File: adc_mode_and_input_control.sv
// converter mode handling, calibration sequencing and control register
//
// The APB register port was chosen for this implementation.
`include "adc_ctl_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_mode_and_input_control
	import adc_ctl_pkg::*;
#(
	parameter int CAL_CYCLES = `CAL_CYCLES,
	parameter int COEF_W = 24
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// modulator side
	input wire logic conv_done,
	input wire logic [COEF_W-1:0] cal_value,
	output logic conv_reset,
	output logic filter_hold,
	output logic mod_clk_en,
	output logic cal_busy,
	output logic [7:0] sf_active,
	// input mux and range
	output logic [3:0] pos_input,
	output logic neg_common,
	output logic [2:0] cal_pair,
	output logic bipolar,
	output logic [2:0] range_code,
	output logic [9:0] full_scale_mv,
	// coefficients of the selected pair
	output logic [COEF_W-1:0] zero_coef,
	output logic [COEF_W-1:0] full_coef
);
	localparam int CNT_W = $clog2(CAL_CYCLES + 1);
	localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
	conv_mode_t mode;
	cal_state_t cal_state;
	logic chop_en;
	logic cfg_sel;
	logic [7:0] cctl;
	logic [7:0] sf_user;
	logic ready;
	logic [CNT_W-1:0] cal_cnt;
	logic [COEF_W-1:0] zero_mem [`NUM_PAIRS];
	logic [COEF_W-1:0] full_mem [`NUM_PAIRS];
	logic acc;
	logic wr;
	logic mode_wr;
	logic cal_start;
	logic cal_fin;
	logic [31:0] next_prdata;
	logic next_err;
	logic [3:0] next_pos;
	logic next_neg;
	logic [2:0] next_pair;
	logic [2:0] pair_idx;
	// checks sample on mclk and rest while reset is high
	default clocking dflt_cb @(posedge mclk); endclocking
	default disable iff (rst);
	// apb access phase and write strobes
	assign acc = psel & penable;
	assign wr = acc & pready & pwrite;
	assign mode_wr = wr & (paddr == `MODE_ADDR);
	assign cal_start = mode_wr & pwdata[2];
	assign cal_fin = (cal_state == CAL_RUN) & (cal_cnt == CAL_LAST) & ~mode_wr;
	assign pair_idx = (cal_pair == 3'h0) ? 3'h0 : 3'(cal_pair - 3'h1);
	// one wait state so read data comes from a flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= acc & ~pready;
		end
	end
	// read mux; unmapped addresses answer with an error
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr)
			`STATUS_ADDR: next_prdata = {30'h0, cal_busy, ready};
			`MODE_ADDR: next_prdata = {26'h0, cfg_sel, chop_en, 1'b0, mode};
			`CCTL_ADDR: next_prdata = {24'h0, cctl};
			`FILT_ADDR: next_prdata = {24'h0, sf_user};
			`SFACT_ADDR: next_prdata = {24'h0, sf_active};
			`DECODE_ADDR: next_prdata = {24'h0, cal_pair, neg_common, pos_input};
			default: next_err = 1'b1;
		endcase
	end
	// read data and error are presented with pready
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (acc & ~pready) begin
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_err;
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end
	property p_cctl_read;
		(acc & ~pready & ~pwrite & (paddr == `CCTL_ADDR)) |=> pready & (prdata[7:0] == cctl);
	endproperty
	a_cctl_read: assert property (p_cctl_read) else $error("control readback mismatch");
	// control register; the serial order msb first maps to bit 7 here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cctl <= `CCTL_RST;
		end else if (wr & (paddr == `CCTL_ADDR)) begin
			cctl <= pwdata[7:0];
		end
	end
	// user filter rate word
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sf_user <= `SF_RST;
		end else if (wr & (paddr == `FILT_ADDR)) begin
			sf_user <= pwdata[7:0];
		end
	end
	// mode field; a host write always beats hardware return to idle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode <= MD_PDOWN;
			chop_en <= 1'b0;
			cfg_sel <= 1'b0;
		end else if (mode_wr) begin
			mode <= conv_mode_t'(pwdata[2:0]);
			chop_en <= pwdata[`MODE_CHOP_BIT];
			cfg_sel <= pwdata[`MODE_CFG_BIT];
		end else if (cal_fin) begin
			mode <= MD_IDLE;
		end else if (conv_done & (mode == MD_SINGLE)) begin
			mode <= MD_IDLE;
		end
	end
	// converter reset on every mode write, changed or not
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			conv_reset <= 1'b0;
		end else begin
			conv_reset <= mode_wr;
		end
	end
	property p_conv_reset;
		mode_wr |=> conv_reset;
	endproperty
	a_conv_reset: assert property (p_conv_reset) else $error("no converter reset");
	property p_same_reset;
		(mode_wr & (pwdata[2:0] == mode)) |=> conv_reset & $stable(mode);
	endproperty
	a_same_reset: assert property (p_same_reset) else $error("no reset on same mode");
	// calibration sequencer; a new mode write aborts a running one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cal_state <= CAL_OFF;
			cal_cnt <= '0;
		end else begin
			case (cal_state)
				CAL_OFF: begin
					cal_cnt <= '0;
					if (cal_start) begin
						cal_state <= CAL_RUN;
					end
				end
				CAL_RUN: begin
					if (mode_wr) begin
						cal_cnt <= '0;
						cal_state <= cal_start ? CAL_RUN : CAL_OFF;
					end else if (cal_fin) begin
						cal_state <= CAL_END;
					end else begin
						cal_cnt <= cal_cnt + 1'b1;
					end
				end
				CAL_END: begin
					cal_cnt <= '0;
					cal_state <= cal_start ? CAL_RUN : CAL_OFF;
				end
				default: cal_state <= CAL_OFF;
			endcase
		end
	end
	// busy mirrors the next run state, so an abort drops it at once
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cal_busy <= 1'b0;
		end else begin
			cal_busy <= cal_start | ((cal_state == CAL_RUN) & ~cal_fin & ~mode_wr);
		end
	end
	// ready flag; a set in the clearing cycle wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ready <= 1'b0;
		end else if (cal_fin | (conv_done & (mode == MD_SINGLE | mode == MD_CONT))) begin
			ready <= 1'b1;
		end else if (cal_start) begin
			ready <= 1'b0;
		end
	end
	property p_cal_clear;
		(cal_start & ~conv_done) |=> ~ready & cal_busy;
	endproperty
	a_cal_clear: assert property (p_cal_clear) else $error("ready not cleared");
	property p_cal_end;
		cal_fin |=> (mode == MD_IDLE) & ready & ~cal_busy;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("no return to idle");
	// coefficient store, zero codes have bit 0 low
	always_ff @(posedge mclk) begin
		if (cal_fin) begin
			if (mode[0]) begin
				full_mem[pair_idx] <= cal_value;
			end else begin
				zero_mem[pair_idx] <= cal_value;
			end
		end
	end
	// selected pair coefficients; unwritten entries read as unknown
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			zero_coef <= '0;
			full_coef <= '0;
		end else begin
			zero_coef <= zero_mem[pair_idx];
			full_coef <= full_mem[pair_idx];
		end
	end
	// filter rate word seen by the decimator
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sf_active <= `SF_RST;
		end else if (cal_busy & chop_en) begin
			sf_active <= `SF_MAX;
		end else begin
			sf_active <= sf_user;
		end
	end
	property p_chop_sf;
		(cal_busy & chop_en) |=> (sf_active == `SF_MAX);
	endproperty
	a_chop_sf: assert property (p_chop_sf) else $error("chopped cal not at max rate");
	property p_restore_sf;
		($fell(cal_busy) & $stable(sf_user)) |=> (sf_active == $past(sf_user));
	endproperty
	a_restore_sf: assert property (p_restore_sf) else $error("filter word not restored");
	property p_nochop_sf;
		(cal_busy & ~chop_en) |=> (sf_active == $past(sf_user));
	endproperty
	a_nochop_sf: assert property (p_nochop_sf) else $error("unchopped cal changed rate");
	// idle holds the filter with the modulator clock running; clocks stop only in power-down
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			filter_hold <= 1'b1;
			mod_clk_en <= 1'b0;
		end else begin
			filter_hold <= (mode == MD_IDLE) | (mode == MD_PDOWN);
			mod_clk_en <= (mode != MD_PDOWN);
		end
	end
	property p_idle_hold;
		(mode == MD_IDLE) |=> filter_hold & mod_clk_en;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle did not hold filter");
	// input select decode; codes past 0101 are not decoded yet
	always_comb begin
		next_pos = 4'h0;
		next_neg = 1'b0;
		next_pair = 3'h1;
		case (cctl[7:4])
			4'h0, 4'h1, 4'h2, 4'h3: begin
				next_pos = 4'(cctl[7:4] + 4'h1);
				next_neg = 1'b1;
				next_pair = 3'(cctl[6:4] + 3'h1);
			end
			4'h4: begin
				next_pos = 4'h5;
				next_neg = 1'b1;
				next_pair = cfg_sel ? 3'h5 : 3'h1;
			end
			4'h5: begin
				next_pos = 4'h6;
				next_neg = 1'b1;
				next_pair = cfg_sel ? 3'h1 : 3'h2;
			end
			default: next_pair = 3'h1;
		endcase
	end
	// field outputs from the control register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pos_input <= 4'h1;
			neg_common <= 1'b1;
			cal_pair <= 3'h1;
			bipolar <= 1'b0;
			range_code <= 3'h7;
			full_scale_mv <= `RANGE_BASE_MV << `RANGE_TOP_CODE;
		end else begin
			pos_input <= next_pos;
			neg_common <= next_neg;
			cal_pair <= next_pair;
			bipolar <= cctl[`CCTL_BIP_BIT];
			range_code <= cctl[2:0];
			if (cctl[2:0] > `RANGE_TOP_CODE) begin
				full_scale_mv <= `RANGE_BASE_MV << `RANGE_TOP_CODE;
			end else begin
				full_scale_mv <= `RANGE_BASE_MV << cctl[2:0];
			end
		end
	end

	property p_low_codes;
		(cctl[7:6] == 2'b00) |=> neg_common & (pos_input == 4'($past(cctl[7:4]) + 4'h1));
	endproperty
	a_low_codes: assert property (p_low_codes) else $error("low input code decode wrong");
endmodule
`default_nettype wire

// File: test_adc_mode_and_input_control.sv
// self-checking bench for the mode and input control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_mode_and_input_control
	import adc_ctl_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [23:0] val = 24'h0;
	logic [31:0] prdata;
	logic pready, pslverr, conv_done, conv_reset, filter_hold, mod_clk_en, cal_busy, neg_common;
	logic [23:0] cal_value, zero_coef, full_coef;
	logic [7:0] sf_active, uw, cw;
	logic [3:0] pos_input;
	logic [2:0] cal_pair, range_code, rg, ep;
	logic bipolar;
	logic [9:0] full_scale_mv;
	logic [32:0] q[$];
	int n_fail = 0, checked = 0, n_rst = 0, k;
	adc_mode_and_input_control #(.CAL_CYCLES(8), .COEF_W(24)) dut (.mclk(mclk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
		.cal_value(cal_value), .conv_reset(conv_reset), .filter_hold(filter_hold),
		.mod_clk_en(mod_clk_en), .cal_busy(cal_busy), .sf_active(sf_active),
		.pos_input(pos_input), .neg_common(neg_common), .cal_pair(cal_pair),
		.bipolar(bipolar), .range_code(range_code), .full_scale_mv(full_scale_mv),
		.zero_coef(zero_coef), .full_coef(full_coef));
	adc_mod_model model (.mclk(mclk), .rst(rst), .fire(fire), .val(val),
		.conv_done(conv_done), .cal_value(cal_value));
	// free-running clock, 50 ns period
	always #25 mclk = ~mclk;
	task final_report;
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		checked++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask
	// one apb transfer; the expected answer is queued for the monitor
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back(e);
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			chk("pready", 1, 0);
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// bounded wait for the calibration busy level
	task wait_busy(input logic want);
		for (int i = 0; i < 100; i++) begin
			@(posedge mclk);
			if (cal_busy === want) return;
		end
		chk("cal_busy", want, ~want);
		final_report();
	endtask
	// monitor: every answer against the oldest note
	always @(posedge mclk) begin
		if (pready === 1'b1) begin
			if (q.size() == 0) begin
				chk("queue", 1, 0);
			end else begin
				chk("apb answer", q.pop_front(), {pslverr, prdata});
			end
		end
	end
	// converter reset pulses are counted, not sampled once
	always @(posedge mclk) begin
		if (conv_reset === 1'b1) n_rst <= n_rst + 1;
	end
	initial begin
		void'($urandom(67647));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		apb(0, 8'h08, 0, {1'b0, 32'h07});
		chk("range_code", 7, range_code);
		chk("bipolar", 0, bipolar);
		apb(0, 8'h40, 0, {1'b1, 32'h0});
		apb(1, 8'h40, 32'h5A, {1'b1, 32'h0});
		// every decoded input code in both channel configurations
		for (k = 0; k < 12; k++) begin
			rg = $urandom_range(5, 0);
			cw = {4'(k % 6), k[0], rg};
			// configuration select sits in mode bit 5
			apb(1, 8'h04, {26'h0, 1'(k / 6), 2'h0, MD_IDLE}, 0);
			apb(1, 8'h08, cw, 0);
			apb(0, 8'h08, 0, {1'b0, 24'h0, cw});
			ep = (k % 6 < 4) ? k % 6 + 1 : (k / 6 == 0) ? k % 6 - 3 : (k % 6 == 4) ? 5 : 1;
			chk("pos_input", k % 6 + 1, pos_input);
			chk("neg_common", 1, neg_common);
			chk("cal_pair", ep, cal_pair);
			chk("bipolar", k[0], bipolar);
			chk("range_code", rg, range_code);
			chk("full_scale", 20 << rg, full_scale_mv);
		end
		chk("filter_hold", 1, filter_hold);
		chk("mod_clk_en", 1, mod_clk_en);
		// a changed value, then the same value again, each resets
		k = n_rst;
		apb(1, 8'h04, MD_PDOWN, 0);
		apb(1, 8'h04, MD_PDOWN, 0);
		repeat (2) @(posedge mclk);
		chk("conv_reset", k + 2, n_rst);
		// chopped zero-scale calibration on pair 1
		uw = $urandom();
		val <= $urandom();
		apb(1, 8'h08, 32'h07, 0);
		apb(1, 8'h0C, uw, 0);
		apb(1, 8'h04, 32'h10 | MD_ZS_INT, 0);
		wait_busy(1);
		@(posedge mclk);
		#1 chk("sf_active", 8'hFF, sf_active);
		apb(0, 8'h00, 0, {1'b0, 32'h02});
		wait_busy(0);
		@(posedge mclk);
		#1 chk("sf_active", uw, sf_active);
		chk("zero_coef", val, zero_coef);
		apb(0, 8'h04, 0, {1'b0, 32'h10 | MD_IDLE});
		apb(0, 8'h00, 0, {1'b0, 32'h01});
		// unchopped full-scale calibration
		val <= $urandom();
		apb(1, 8'h04, MD_FS_INT, 0);
		wait_busy(1);
		@(posedge mclk);
		#1 chk("sf_active", uw, sf_active);
		// ready was set by the first calibration, so this read sees the clear
		apb(0, 8'h00, 0, {1'b0, 32'h02});
		wait_busy(0);
		@(posedge mclk);
		#1 chk("full_coef", val, full_coef);
		repeat (4) @(posedge mclk);
		final_report();
	end
endmodule
`default_nettype wire
